// ===== half_period_divider.sv
// toggling divider giving a 50:50 clock and a pulse on each rising edge
// assumes the half period is held steady while run_i is high
`timescale 1ns/100ps
`default_nettype none
module half_period_divider #(
  parameter int W = 16
) (
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] half_i,
  output var  logic         clk_o,
  output var  logic         rise_o
);

  logic [W-1:0] count_q;
  logic         active;
  logic         wrap;

  // a zero half period means the clock is stopped
  assign active = run_i && (half_i != '0);
  assign wrap   = (count_q == half_i - W'(1));

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !active) begin
      count_q <= '0;
      clk_o   <= 1'b0;
      rise_o  <= 1'b0;
    end else begin
      count_q <= wrap ? '0 : count_q + W'(1);
      clk_o   <= wrap ? !clk_o : clk_o;
      rise_o  <= wrap && !clk_o;
    end
  end

endmodule : half_period_divider
`default_nettype wire

// ===== host_model.sv
// host model: drives the 3-wire programming port and the tx bit line
// assumes send_word is called just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic clock_i,
  input  wire logic tx_bit_clock_i,
  output var  logic serial_clock_o,
  output var  logic serial_data_o,
  output var  logic load_strobe_o,
  output var  logic tx_bit_o
);
  logic tx_clk_q;
  initial begin
    serial_clock_o = 1'b0;
    serial_data_o = 1'b0;
    load_strobe_o = 1'b0;
    tx_bit_o = 1'b0;
    tx_clk_q = 1'b0;
  end
  // alternating bits so a stale sample shows up
  always @(posedge clock_i) begin
    tx_clk_q <= tx_bit_clock_i;
    if (tx_clk_q && !tx_bit_clock_i) tx_bit_o <= ~tx_bit_o;
  end
  // levels held two cycles: the port samples pins on clock_i
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      serial_data_o <= w[i];
      repeat (2) @(posedge clock_i);
      serial_clock_o <= 1'b1;
      repeat (2) @(posedge clock_i);
      serial_clock_o <= 1'b0;
    end
    serial_data_o <= ~w[0];
    repeat (2) @(posedge clock_i);
    load_strobe_o <= 1'b1;
    repeat (2) @(posedge clock_i);
    load_strobe_o <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask : send_word
endmodule : host_model
`default_nettype wire

// ===== serial_port_pkg.sv
// constants, field layouts and register map of the serial programming and tx bit port
// assumes a single 100 MHz clock and an APB master with 32-bit data
package serial_port_pkg;

  localparam int WORD_W    = 32;
  localparam int CTRL_W    = 2;
  localparam int NUM_LATCH = 4;

  // which latch holds which field
  localparam logic [1:0] LATCH_REF = 2'h0;
  localparam logic [1:0] LATCH_MOD = 2'h3;

  // reference latch fields
  localparam int CLKDIV_LSB   = 2;
  localparam int CLKDIV_W     = 8;
  localparam int XTAL_DIS_BIT = 10;

  // modulation latch fields
  localparam int MODE_LSB   = 2;
  localparam int RATE_LSB   = 4;
  localparam int RATE_W     = 16;
  localparam int MUXSEL_LSB = 20;

  typedef enum logic [1:0] {
    MOD_FSK  = 2'b00,
    MOD_GFSK = 2'b01,
    MOD_OOK  = 2'b10,
    MOD_GOOK = 2'b11
  } mod_mode_t;

  typedef enum logic [1:0] {
    MUX_LOCK    = 2'b00,
    MUX_BATTERY = 2'b01,
    MUX_REG_RDY = 2'b10,
    MUX_LOW     = 2'b11
  } mux_sel_t;

  // apb byte offsets
  localparam logic [7:0] OFS_LATCH0 = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;
  localparam logic [7:0] OFS_CTRL   = 8'h18;
  localparam logic [7:0] OFS_SHIFT  = 8'h1C;

  // event bits of status and mask
  localparam int EV_LOADED = 0;
  localparam int EV_TXBIT  = 1;
  localparam int EV_UNLOCK = 2;
  localparam int EV_W      = 3;

  localparam int CTRL_TX_BIT_CLOCK_EN = 0;
  localparam int CTRL_W_BITS   = 1;

  localparam logic [CTRL_W_BITS-1:0] CTRL_RST   = 1'h1;
  localparam logic [EV_W-1:0]        MASK_RST   = 3'h0;
  localparam logic [WORD_W-1:0]      LATCH_RST  = 32'h0000_0000;

endpackage : serial_port_pkg

// ===== serial_program_port.sv
// host-facing digital logic of the transmitter: serial programming, latches,
// tx bit clock, status mux, divided reference clock and an apb view of the latches, shift word, events, mask and ctrl
// assumes every pin input is synchronous to clock_i; clock_i stands in for the reference
`timescale 1ns/100ps
`default_nettype none
module serial_program_port (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // 3-wire programming port
  input  wire logic        serial_clock_i,
  input  wire logic        serial_data_i,
  input  wire logic        load_strobe_i,
  input  wire logic        chip_power_enable_i,
  // transmit data
  input  wire logic        tx_bit_input_i,
  output var  logic        tx_bit_clock_o,
  output var  logic        tx_bit_o,
  output var  logic        tx_bit_valid_o,
  // analog indications
  input  wire logic        pll_lock_i,
  input  wire logic        battery_ok_i,
  input  wire logic        regulator_ready_i,
  output var  logic        muxed_status_out_o,
  output var  logic        divided_ref_clock_out_o,
  output var  logic        xtal_osc_enable_o,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  output var  logic        irq_o
);

  localparam int W = serial_port_pkg::WORD_W;
  localparam int N = serial_port_pkg::NUM_LATCH;
  localparam int E = serial_port_pkg::EV_W;

  logic [W-1:0] shift_word;
  logic [W-1:0] latch_q [N];
  logic         load_prev_q;
  logic         load_rise;
  logic         powered;
  logic [1:0]   dest;

  logic [W-1:0]  ref_latch;
  logic [W-1:0]  mod_latch;
  logic          xtal_disable;
  logic [serial_port_pkg::CLKDIV_W-1:0] clkdiv_half;
  logic [serial_port_pkg::RATE_W-1:0]   rate_half;
  serial_port_pkg::mod_mode_t           mode;
  serial_port_pkg::mux_sel_t            mux_sel;
  logic          gaussian;
  logic          tx_bit_clock_run;
  logic          tx_bit_clock;
  logic          tx_bit_clock_rise;
  logic          refclk;
  logic          mux_value;

  logic [serial_port_pkg::CTRL_W_BITS-1:0] ctrl_q;
  logic [E-1:0]  status_q;
  logic [E-1:0]  mask_q;
  logic [E-1:0]  events;
  logic [E-1:0]  w1c;
  logic          lock_prev_q;

  logic          access;
  logic          setup_rd;
  logic          commit_wr;
  logic          hit_latch;
  logic          hit_status;
  logic          hit_mask;
  logic          hit_ctrl;
  logic          hit_shift;
  logic          mapped;
  logic [31:0]   rd_value;

  // programming path
  assign powered   = chip_power_enable_i;
  assign load_rise = load_strobe_i && !load_prev_q;
  assign dest      = shift_word[serial_port_pkg::CTRL_W-1:0];

  serial_word_shifter u_shifter (
    .clock_i        (clock_i),
    .sys_rst_i      (sys_rst_i),
    .clear_i        (!powered),
    .serial_clock_i (serial_clock_i),
    .serial_data_i  (serial_data_i),
    .word_o         (shift_word)
  );

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      load_prev_q <= 1'b0;
    end else begin
      load_prev_q <= load_strobe_i;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_latch
      always_ff @(posedge clock_i) begin
        if (sys_rst_i || !powered) begin
          latch_q[gi] <= serial_port_pkg::LATCH_RST;
        end else if (load_rise && dest == 2'(gi)) begin
          latch_q[gi] <= shift_word;
        end
      end
    end
  endgenerate

  // field decode
  assign ref_latch    = latch_q[serial_port_pkg::LATCH_REF];
  assign mod_latch    = latch_q[serial_port_pkg::LATCH_MOD];
  assign xtal_disable = ref_latch[serial_port_pkg::XTAL_DIS_BIT];
  assign clkdiv_half  = ref_latch[serial_port_pkg::CLKDIV_LSB +: serial_port_pkg::CLKDIV_W];
  assign rate_half    = mod_latch[serial_port_pkg::RATE_LSB +: serial_port_pkg::RATE_W];
  assign mode         = serial_port_pkg::mod_mode_t'(mod_latch[serial_port_pkg::MODE_LSB +: 2]);
  assign mux_sel      = serial_port_pkg::mux_sel_t'(mod_latch[serial_port_pkg::MUXSEL_LSB +: 2]);

  assign gaussian  = (mode == serial_port_pkg::MOD_GFSK) || (mode == serial_port_pkg::MOD_GOOK);
  // software may hold the bit clock off even in a Gaussian mode
  assign tx_bit_clock_run = powered && gaussian && ctrl_q[serial_port_pkg::CTRL_TX_BIT_CLOCK_EN];

  // one bit clock period is two half periods of rate_half cycles each
  half_period_divider #(
    .W (serial_port_pkg::RATE_W)
  ) u_tx_bit_clock (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (tx_bit_clock_run),
    .half_i    (rate_half),
    .clk_o     (tx_bit_clock),
    .rise_o    (tx_bit_clock_rise)
  );

  // ref clock only runs while the oscillator does
  half_period_divider #(
    .W (serial_port_pkg::CLKDIV_W)
  ) u_refclk (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (xtal_osc_enable_o),
    .half_i    (clkdiv_half),
    .clk_o     (refclk),
    .rise_o    ()
  );

  always_comb begin
    case (mux_sel)
      serial_port_pkg::MUX_LOCK:    mux_value = pll_lock_i;
      serial_port_pkg::MUX_BATTERY: mux_value = battery_ok_i;
      serial_port_pkg::MUX_REG_RDY: mux_value = regulator_ready_i;
      default:                      mux_value = 1'b0;
    endcase
  end

  // pin outputs; the bit is taken on the edge at which the clock output rises,
  // mid-way through the period in which the host holds it
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_bit_clock_o          <= 1'b0;
      tx_bit_o                <= 1'b0;
      tx_bit_valid_o          <= 1'b0;
      muxed_status_out_o      <= 1'b0;
      divided_ref_clock_out_o <= 1'b0;
      xtal_osc_enable_o       <= 1'b0;
    end else begin
      tx_bit_clock_o          <= tx_bit_clock;
      tx_bit_valid_o          <= tx_bit_clock_rise;
      if (tx_bit_clock_rise) begin
        tx_bit_o <= tx_bit_input_i;
      end
      muxed_status_out_o      <= powered && mux_value;
      divided_ref_clock_out_o <= refclk;
      // external reference case relies on the host setting the disable bit
      xtal_osc_enable_o       <= powered && !xtal_disable;
    end
  end

  // events and interrupt
  assign events[serial_port_pkg::EV_LOADED] = load_rise && powered;
  assign events[serial_port_pkg::EV_TXBIT]  = tx_bit_clock_rise;
  assign events[serial_port_pkg::EV_UNLOCK] = lock_prev_q && !pll_lock_i;
  assign w1c = (commit_wr && hit_status) ? pwdata_i[E-1:0] : '0;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      status_q    <= '0;
      lock_prev_q <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      // a new event beats a simultaneous clear
      status_q    <= (status_q & ~w1c) | events;
      lock_prev_q <= pll_lock_i;
      irq_o       <= |(status_q & mask_q);
    end
  end

  // apb slave: one wait state, write commits on the pready edge
  assign access     = psel_i && penable_i;
  assign setup_rd   = access && !pready_o;
  assign commit_wr  = access && pready_o && pwrite_i;
  assign hit_latch  = paddr_i < serial_port_pkg::OFS_STATUS && paddr_i[1:0] == 2'b00;
  assign hit_status = paddr_i == serial_port_pkg::OFS_STATUS;
  assign hit_mask   = paddr_i == serial_port_pkg::OFS_MASK;
  assign hit_ctrl   = paddr_i == serial_port_pkg::OFS_CTRL;
  assign hit_shift  = paddr_i == serial_port_pkg::OFS_SHIFT;
  assign mapped     = hit_latch || hit_status || hit_mask || hit_ctrl || hit_shift;

  always_comb begin
    rd_value = 32'h0000_0000;
    if (hit_latch) begin
      rd_value = latch_q[paddr_i[3:2]];
    end else if (hit_status) begin
      rd_value[E-1:0] = status_q;
    end else if (hit_mask) begin
      rd_value[E-1:0] = mask_q;
    end else if (hit_ctrl) begin
      rd_value[serial_port_pkg::CTRL_W_BITS-1:0] = ctrl_q;
    end else if (hit_shift) begin
      rd_value = shift_word;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      mask_q    <= serial_port_pkg::MASK_RST;
      ctrl_q    <= serial_port_pkg::CTRL_RST;
    end else begin
      pready_o  <= setup_rd;
      pslverr_o <= setup_rd && !mapped;
      if (setup_rd && !pwrite_i) begin
        prdata_o <= mapped ? rd_value : 32'h0000_0000;
      end
      if (commit_wr && hit_mask) begin
        mask_q <= pwdata_i[E-1:0];
      end
      if (commit_wr && hit_ctrl) begin
        ctrl_q <= pwdata_i[serial_port_pkg::CTRL_W_BITS-1:0];
      end
    end
  end

endmodule : serial_program_port
`default_nettype wire

// ===== serial_program_port_sva.sv
// checker on the top ports of the serial program port
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module serial_program_port_sva (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic chip_power_enable_i,
  input wire logic tx_bit_input_i,
  input wire logic tx_bit_clock_o,
  input wire logic tx_bit_o,
  input wire logic tx_bit_valid_o,
  input wire logic muxed_status_out_o,
  input wire logic xtal_osc_enable_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_ready_wait: assert property (psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_valid_follows: assert property ($rose(tx_bit_clock_o) |-> tx_bit_valid_o)
    else $error("no tx bit sample after bit clock rise");
  a_sample_bit: assert property (tx_bit_valid_o |-> tx_bit_o == $past(tx_bit_input_i))
    else $error("tx bit not the sampled input");
  a_valid_pulse: assert property (tx_bit_valid_o |=> !tx_bit_valid_o)
    else $error("tx bit valid longer than one cycle");
  a_tx_bit_clock_off: assert property (!chip_power_enable_i [*3] |-> !tx_bit_clock_o)
    else $error("bit clock runs while unpowered");
  a_osc_off: assert property (!chip_power_enable_i [*3] |-> !xtal_osc_enable_o)
    else $error("oscillator on while unpowered");
  a_status_off: assert property (!chip_power_enable_i [*3] |-> !muxed_status_out_o)
    else $error("status output high while unpowered");
endmodule : serial_program_port_sva
`default_nettype wire

// ===== serial_word_shifter.sv
// 32-bit shift register fed by the 3-wire serial port
// assumes serial clock and data already synchronous to clock_i
`timescale 1ns/100ps
`default_nettype none
module serial_word_shifter (
  input  wire logic                               clock_i,
  input  wire logic                               sys_rst_i,
  input  wire logic                               clear_i,
  input  wire logic                               serial_clock_i,
  input  wire logic                               serial_data_i,
  output var  logic [serial_port_pkg::WORD_W-1:0] word_o
);

  logic sclk_prev_q;
  logic sclk_rise;

  assign sclk_rise = serial_clock_i && !sclk_prev_q;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || clear_i) begin
      sclk_prev_q <= 1'b0;
      word_o      <= '0;
    end else begin
      sclk_prev_q <= serial_clock_i;
      if (sclk_rise) begin
        word_o <= {word_o[serial_port_pkg::WORD_W-2:0], serial_data_i};
      end
    end
  end

endmodule : serial_word_shifter
`default_nettype wire

// ===== test_serial_program_port.sv
// testbench of the serial program port: apb tasks, host model, checks
// assumes package, design, checker and host model compiled first
`timescale 1ns/100ps
`default_nettype none
module test_serial_program_port;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic chip_power_enable_i = 1'b1, pll_lock_i = 1'b1, battery_ok_i = 1'b0, regulator_ready_i = 1'b1;
  wire logic sclk, sdat, strobe, txin, tx_bit_clock, txb, txv, mux, refclk, osc, pready, perr, irq;
  wire logic [31:0] prdata;
  logic [31:0] r;
  logic e;
  int fails = 0, compares = 0, hi, lo;
  serial_program_port dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .serial_clock_i(sclk), .serial_data_i(sdat),
    .load_strobe_i(strobe), .chip_power_enable_i(chip_power_enable_i), .tx_bit_input_i(txin),
    .tx_bit_clock_o(tx_bit_clock), .tx_bit_o(txb), .tx_bit_valid_o(txv), .pll_lock_i(pll_lock_i),
    .battery_ok_i(battery_ok_i), .regulator_ready_i(regulator_ready_i), .muxed_status_out_o(mux),
    .divided_ref_clock_out_o(refclk), .xtal_osc_enable_o(osc), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .irq_o(irq));
  host_model host (
    .clock_i(clock_i), .tx_bit_clock_i(tx_bit_clock), .serial_clock_o(sclk), .serial_data_o(sdat),
    .load_strobe_o(strobe), .tx_bit_o(txin));
  initial forever #5 clock_i = ~clock_i;
  task automatic close_out();
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    r = prdata;
    e = perr;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, x, r);
  endtask : rd
  // high and low run lengths of one clock output, in clock_i cycles
  task automatic meas(input logic tx);
    int n;
    for (n = 0; (tx ? tx_bit_clock : refclk) !== 1'b0 && n < 99; n++) @(posedge clock_i);
    for (n = 0; (tx ? tx_bit_clock : refclk) !== 1'b1 && n < 99; n++) @(posedge clock_i);
    for (hi = 0; (tx ? tx_bit_clock : refclk) === 1'b1 && hi < 99; hi++) @(posedge clock_i);
    for (lo = 0; (tx ? tx_bit_clock : refclk) === 1'b0 && lo < 99; lo++) @(posedge clock_i);
  endtask : meas
  task automatic quiet();
    hi = 0;
    // let a clock stopped by the last access drain through the output flop
    repeat (2) @(posedge clock_i);
    repeat (30) begin
      @(posedge clock_i);
      if (tx_bit_clock !== 1'b0) hi++;
    end
  endtask : quiet
  initial begin
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd("ctrl", serial_port_pkg::OFS_CTRL, 32'h0000_0001);
    rd("mask", serial_port_pkg::OFS_MASK, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, {31'h0, e});
    chk("unmapped_data", 32'h0000_0000, r);
    host.send_word(32'hA5C3_0F01);
    rd("shift", serial_port_pkg::OFS_SHIFT, 32'hA5C3_0F01);
    rd("latch1", 8'h04, 32'hA5C3_0F01);
    rd("latch2", 8'h08, 32'h0000_0000);
    rd("latch0", 8'h00, 32'h0000_0000);
    rd("loaded", serial_port_pkg::OFS_STATUS, 32'h0000_0001);
    chk("irq_masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, serial_port_pkg::OFS_MASK, 32'h0000_0001);
    // mask lands on the pready edge, irq follows one edge later
    repeat (2) @(posedge clock_i);
    chk("irq_on", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, serial_port_pkg::OFS_STATUS, 32'h0000_0001);
    rd("cleared", serial_port_pkg::OFS_STATUS, 32'h0000_0000);
    chk("irq_off", 32'h0000_0000, {31'h0, irq});
    host.send_word(32'h0000_000C);
    meas(1'b0);
    chk("ref_high", 32'h0000_0003, hi);
    chk("ref_low", 32'h0000_0003, lo);
    host.send_word(32'h0000_040C);
    chk("osc_dis", 32'h0000_0000, {31'h0, osc});
    for (int i = 0; i < 4; i++) begin
      host.send_word({10'h000, 2'(i), 16'h0004, 2'(i), 2'h3});
      chk("mux", {31'h0, ~i[0]}, {31'h0, mux});
      if (i[0]) begin
        meas(1'b1);
        chk("tx_bit_clock_high", 32'h0000_0004, hi);
        chk("tx_bit_clock_low", 32'h0000_0004, lo);
      end else begin
        quiet();
        chk("tx_bit_clock_idle", 32'h0000_0000, hi);
      end
    end
    apb(1'b1, serial_port_pkg::OFS_CTRL, 32'h0000_0000);
    quiet();
    chk("tx_bit_clock_ctrl", 32'h0000_0000, hi);
    pll_lock_i <= 1'b0;
    apb(1'b0, serial_port_pkg::OFS_STATUS, 32'h0000_0000);
    chk("unlock", 32'h0000_0001, {31'h0, r[serial_port_pkg::EV_UNLOCK]});
    chip_power_enable_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    chip_power_enable_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd("lost3", 8'h0C, 32'h0000_0000);
    rd("lost1", 8'h04, 32'h0000_0000);
    chk("osc_on", 32'h0000_0001, {31'h0, osc});
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    close_out();
  end
endmodule : test_serial_program_port
bind serial_program_port serial_program_port_sva chk_i (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .chip_power_enable_i(chip_power_enable_i),
  .tx_bit_input_i(tx_bit_input_i), .tx_bit_clock_o(tx_bit_clock_o), .tx_bit_o(tx_bit_o),
  .tx_bit_valid_o(tx_bit_valid_o), .muxed_status_out_o(muxed_status_out_o),
  .xtal_osc_enable_o(xtal_osc_enable_o), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o));
`default_nettype wire
